// ### hdl/uec_pkg.sv
package uec_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] UEC_CFG_OFFSET  = 16'h2C02;
    localparam logic [7:0]  UEC_CFG_RESET   = 8'hC8;
    // Only power select, detach, join and wake bits hold state
    localparam logic [7:0]  UEC_CFG_WR_MASK = 8'hCA;
    localparam logic [7:0]  UEC_ZERO_BYTE   = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int UEC_BIT_PWR   = 7;
    localparam int UEC_BIT_DET   = 6;
    localparam int UEC_BIT_JOIN  = 3;
    localparam int UEC_BIT_SPEED = 2;
    localparam int UEC_BIT_WAKE  = 1;

    // ------------------------------------------------------------
    // Buffer descriptors
    // ------------------------------------------------------------
    localparam int UEC_EP_W = 4;

    typedef enum logic [0:0] {
        UEC_DIR_OUT = 1'b0,
        UEC_DIR_IN  = 1'b1
    } uec_dir_t;

    // ------------------------------------------------------------
    // Read view: stored bits plus live speed, reserved bits zero
    // ------------------------------------------------------------
    function automatic logic [7:0] uec_cfg_view(input logic [7:0] cfg, input logic hs);
        logic [7:0] v;
        v = cfg & UEC_CFG_WR_MASK;
        v[UEC_BIT_SPEED] = hs;
        return v;
    endfunction

endpackage

// ### hdl/uec_buf_join.sv
`timescale 1ns/10ps
module uec_buf_join #(
    parameter int EP_W = uec_pkg::UEC_EP_W
) (
    input  wire logic            clk,
    input  wire logic            srst,
    input  wire logic            join_mode,
    input  wire logic            buf_start,
    input  wire uec_pkg::uec_dir_t buf_dir,
    input  wire logic [EP_W-1:0] buf_ep,
    input  wire logic            bus_reset,
    output logic                 buf_join,
    output logic                 buf_join_valid
);

    // ------------------------------------------------------------
    // Previous buffer history
    // ------------------------------------------------------------
    logic              have_prev_ff;
    uec_pkg::uec_dir_t prev_dir_ff;
    logic [EP_W-1:0]   prev_ep_ff;
    logic              join_ff;
    logic              valid_ff;

    wire same_stream = have_prev_ff && (prev_dir_ff == buf_dir) && (prev_ep_ff == buf_ep);
    wire nxt_join    = join_mode && same_stream;

    always_ff @(posedge clk) begin
        if (srst || bus_reset) begin
            have_prev_ff <= 1'b0;
            prev_dir_ff  <= uec_pkg::UEC_DIR_OUT;
            prev_ep_ff   <= '0;
        end else if (buf_start) begin
            have_prev_ff <= 1'b1;
            prev_dir_ff  <= buf_dir;
            prev_ep_ff   <= buf_ep;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            join_ff  <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= buf_start;
            if (buf_start) begin
                join_ff <= nxt_join;
            end
        end
    end

    assign buf_join       = join_ff;
    assign buf_join_valid = valid_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_match_start;
        buf_start && !bus_reset && same_stream;
    endsequence

    a_join_same_stream: assert property (@(posedge clk) disable iff (srst)
        s_match_start ##0 join_mode |=> buf_join && buf_join_valid)
        else $error("matching buffer not joined");

    a_join_mode_off: assert property (@(posedge clk) disable iff (srst)
        buf_start && !join_mode |=> !buf_join ##1 (buf_start || !buf_join))
        else $error("join with join mode off");

    a_join_new_stream: assert property (@(posedge clk) disable iff (srst)
        buf_start && !same_stream |=> buf_join_valid && !buf_join)
        else $error("different stream joined");

endmodule

// ### hdl/uec_top.sv
`timescale 1ns/10ps
module uec_top (
    input  wire logic                          SYS_CLK,
    input  wire logic                          SRST,
    input  wire logic [15:0]                   REG_ADDR,
    input  wire logic                          REG_WR,
    input  wire logic [7:0]                    REG_WDATA,
    input  wire logic                          REG_RD,
    output logic [7:0]                         REG_RDATA,
    output logic                               REG_RVALID,
    input  wire logic                          HS_MODE,
    input  wire logic                          USB_BUS_RESET,
    input  wire logic                          HOST_SET_RWU,
    input  wire logic                          HOST_CLR_RWU,
    input  wire logic                          STD_REQ,
    output logic                               SELF_POWERED,
    output logic                               SELF_PWR_VALID,
    output logic                               DP_PULLUP_EN,
    output logic                               HS_TERM_EN,
    output logic                               DRIVE_K,
    input  wire logic                          BUF_START,
    input  wire uec_pkg::uec_dir_t             BUF_DIR,
    input  wire logic [uec_pkg::UEC_EP_W-1:0]  BUF_EP,
    output logic                               BUF_JOIN,
    output logic                               BUF_JOIN_VALID
);

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    logic [7:0] cfg_ff;
    logic [7:0] rdata_ff;
    logic       rvalid_ff;

    wire        addr_hit  = (REG_ADDR == uec_pkg::UEC_CFG_OFFSET);
    wire        wr_hit    = REG_WR && addr_hit;
    wire [7:0]  cfg_view  = uec_pkg::uec_cfg_view(cfg_ff, HS_MODE);
    wire [7:0]  nxt_cfg   = REG_WDATA & uec_pkg::UEC_CFG_WR_MASK;
    // Unmapped reads answer zero so software never sees stale data
    wire [7:0]  nxt_rdata = addr_hit ? cfg_view : uec_pkg::UEC_ZERO_BYTE;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            cfg_ff <= uec_pkg::UEC_CFG_RESET;
        end else if (wr_hit) begin
            cfg_ff <= nxt_cfg;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            rdata_ff  <= uec_pkg::UEC_ZERO_BYTE;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= REG_RD;
            if (REG_RD) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign REG_RDATA  = rdata_ff;
    assign REG_RVALID = rvalid_ff;

    // ------------------------------------------------------------
    // Power source reporting
    // ------------------------------------------------------------
    logic self_pwr_ff;
    logic self_vld_ff;

    // Report only: no power path is touched by this bit
    wire nxt_self_pwr = !cfg_ff[uec_pkg::UEC_BIT_PWR];

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            self_pwr_ff <= 1'b0;
            self_vld_ff <= 1'b0;
        end else begin
            self_vld_ff <= STD_REQ;
            if (STD_REQ) begin
                self_pwr_ff <= nxt_self_pwr;
            end
        end
    end

    assign SELF_POWERED   = self_pwr_ff;
    assign SELF_PWR_VALID = self_vld_ff;

    // ------------------------------------------------------------
    // Termination control
    // ------------------------------------------------------------
    logic pullup_ff;
    logic hsterm_ff;

    wire detach      = cfg_ff[uec_pkg::UEC_BIT_DET];
    wire nxt_pullup  = !detach && !HS_MODE;
    wire nxt_hsterm  = !detach && HS_MODE;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            pullup_ff <= 1'b0;
            hsterm_ff <= 1'b0;
        end else begin
            pullup_ff <= nxt_pullup;
            hsterm_ff <= nxt_hsterm;
        end
    end

    assign DP_PULLUP_EN = pullup_ff;
    assign HS_TERM_EN   = hsterm_ff;

    // ------------------------------------------------------------
    // Remote wakeup
    // ------------------------------------------------------------
    logic rwu_en_ff;
    logic drive_k_ff;

    // Set wins over a clear arriving in the same cycle
    wire nxt_rwu_en = HOST_SET_RWU || (rwu_en_ff && !HOST_CLR_RWU && !USB_BUS_RESET);
    // Duration is left to software; K follows the bit while rwu_en_ff is set
    wire nxt_drive_k = cfg_ff[uec_pkg::UEC_BIT_WAKE] && rwu_en_ff;

    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            rwu_en_ff  <= 1'b0;
            drive_k_ff <= 1'b0;
        end else begin
            rwu_en_ff  <= nxt_rwu_en;
            drive_k_ff <= nxt_drive_k;
        end
    end

    assign DRIVE_K = drive_k_ff;

    // ------------------------------------------------------------
    // Buffer joining
    // ------------------------------------------------------------
    uec_buf_join #(
        .EP_W (uec_pkg::UEC_EP_W)
    ) u_join (
        .clk            (SYS_CLK),
        .srst           (SRST),
        .join_mode      (cfg_ff[uec_pkg::UEC_BIT_JOIN]),
        .buf_start      (BUF_START),
        .buf_dir        (BUF_DIR),
        .buf_ep         (BUF_EP),
        .bus_reset      (USB_BUS_RESET),
        .buf_join       (BUF_JOIN),
        .buf_join_valid (BUF_JOIN_VALID)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_cfg_write;
        REG_WR && addr_hit;
    endsequence

    sequence s_cfg_read;
        REG_RD && addr_hit && !REG_WR;
    endsequence

    a_reset_value: assert property (@(posedge SYS_CLK)
        $past(SRST) |-> cfg_ff == uec_pkg::UEC_CFG_RESET)
        else $error("configuration reset value wrong");

    a_power_report: assert property (@(posedge SYS_CLK) disable iff (SRST)
        STD_REQ && !wr_hit |=> SELF_PWR_VALID
            && (SELF_POWERED != cfg_ff[uec_pkg::UEC_BIT_PWR]))
        else $error("power source misreported");

    a_power_no_ctl: assert property (@(posedge SYS_CLK) disable iff (SRST)
        $stable(cfg_ff[uec_pkg::UEC_BIT_DET]) && $stable(HS_MODE)
            && $stable(cfg_ff[uec_pkg::UEC_BIT_WAKE]) && $stable(rwu_en_ff)
            && $changed(cfg_ff[uec_pkg::UEC_BIT_PWR])
            |=> $stable(DP_PULLUP_EN) && $stable(HS_TERM_EN) && $stable(DRIVE_K))
        else $error("power select changed line control");

    a_detach_lines: assert property (@(posedge SYS_CLK) disable iff (SRST)
        cfg_ff[uec_pkg::UEC_BIT_DET] |=> !DP_PULLUP_EN && !HS_TERM_EN)
        else $error("termination present while detached");

    a_attach_lines: assert property (@(posedge SYS_CLK) disable iff (SRST)
        !cfg_ff[uec_pkg::UEC_BIT_DET] |=> (DP_PULLUP_EN == !$past(HS_MODE))
            && (HS_TERM_EN == $past(HS_MODE)))
        else $error("termination wrong while attached");

    a_speed_read: assert property (@(posedge SYS_CLK) disable iff (SRST)
        s_cfg_read |=> REG_RVALID && (REG_RDATA[uec_pkg::UEC_BIT_SPEED] == $past(HS_MODE)))
        else $error("speed bit wrong");

    a_rsvd_zero: assert property (@(posedge SYS_CLK) disable iff (SRST)
        REG_RVALID |-> (REG_RDATA & ~(uec_pkg::UEC_CFG_WR_MASK | 8'h04)) == 8'h00)
        else $error("reserved bit reads one");

    a_write_mask: assert property (@(posedge SYS_CLK) disable iff (SRST)
        s_cfg_write ##1 s_cfg_read |=> REG_RDATA ==
            uec_pkg::uec_cfg_view($past(REG_WDATA, 2), $past(HS_MODE)))
        else $error("write not masked");

    a_wake_k: assert property (@(posedge SYS_CLK) disable iff (SRST)
        DRIVE_K |-> $past(cfg_ff[uec_pkg::UEC_BIT_WAKE]) && $past(rwu_en_ff))
        else $error("K driven without enable");

    a_wake_start: assert property (@(posedge SYS_CLK) disable iff (SRST)
        HOST_SET_RWU ##1 cfg_ff[uec_pkg::UEC_BIT_WAKE] |=> DRIVE_K)
        else $error("K not driven when enabled");

    a_wake_stop: assert property (@(posedge SYS_CLK) disable iff (SRST)
        !cfg_ff[uec_pkg::UEC_BIT_WAKE] |=> !DRIVE_K)
        else $error("K driven after wake bit cleared");

endmodule

// ### verification/uec_host_model.sv
`timescale 1ns/10ps
module uec_host_model (
    input  wire logic                         clk,
    output logic                              hs_mode,
    output logic                              bus_reset,
    output logic                              set_rwu,
    output logic                              clr_rwu,
    output logic                              std_req,
    output logic                              buf_start,
    output uec_pkg::uec_dir_t                 buf_dir,
    output logic [uec_pkg::UEC_EP_W-1:0]      buf_ep
);
    // ------------------------------------------------------------
    // Host side stimulus, changed on falling edges only
    // ------------------------------------------------------------
    initial begin
        {hs_mode, bus_reset, set_rwu, clr_rwu, std_req, buf_start} = 6'h00;
        buf_dir = uec_pkg::UEC_DIR_OUT;
        buf_ep  = 4'h0;
    end

    task automatic speed(input logic v);
        @(negedge clk);
        hs_mode = v;
    endtask

    // Order: bus reset, set feature, clear feature, status request
    task automatic send(input logic [3:0] p);
        @(negedge clk);
        {bus_reset, set_rwu, clr_rwu, std_req} = p;
        @(negedge clk);
        {bus_reset, set_rwu, clr_rwu, std_req} = 4'h0;
    endtask

    task automatic buf_tx(input uec_pkg::uec_dir_t d, input logic [3:0] e);
        @(negedge clk);
        buf_start = 1'b1;
        buf_dir   = d;
        buf_ep    = e;
        @(negedge clk);
        buf_start = 1'b0;
        // Stale qualifiers would hide a design that samples late
        buf_dir   = uec_pkg::uec_dir_t'(~d);
        buf_ep    = ~e;
    endtask
endmodule

// ### verification/usb_engine_config_control_test.sv
`timescale 1ns/10ps
module usb_engine_config_control_test;
    logic              SYS_CLK, SRST, REG_WR, REG_RD, REG_RVALID;
    logic [15:0]       REG_ADDR;
    logic [7:0]        REG_WDATA, REG_RDATA;
    logic              HS_MODE, USB_BUS_RESET, HOST_SET_RWU, HOST_CLR_RWU, STD_REQ;
    logic              SELF_POWERED, SELF_PWR_VALID, DP_PULLUP_EN, HS_TERM_EN, DRIVE_K;
    logic              BUF_START, BUF_JOIN, BUF_JOIN_VALID;
    uec_pkg::uec_dir_t BUF_DIR;
    logic [3:0]        BUF_EP;
    int                errors, comparisons, m_cfg, hs, rwu, last_ok, last_dir, last_ep;
    int                a, d, e;
    bit [31:0]         s;
    logic [3:0]        seq [5];

    uec_top dut_u (
        .SYS_CLK, .SRST, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA, .REG_RVALID,
        .HS_MODE, .USB_BUS_RESET, .HOST_SET_RWU, .HOST_CLR_RWU, .STD_REQ, .SELF_POWERED,
        .SELF_PWR_VALID, .DP_PULLUP_EN, .HS_TERM_EN, .DRIVE_K, .BUF_START, .BUF_DIR,
        .BUF_EP, .BUF_JOIN, .BUF_JOIN_VALID
    );
    uec_host_model host_u (
        .clk(SYS_CLK), .hs_mode(HS_MODE), .bus_reset(USB_BUS_RESET), .set_rwu(HOST_SET_RWU),
        .clr_rwu(HOST_CLR_RWU), .std_req(STD_REQ), .buf_start(BUF_START),
        .buf_dir(BUF_DIR), .buf_ep(BUF_EP)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic int rnd();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return int'(s & 32'h7FFFFFFF);
    endfunction

    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [15:0] ad, input logic [7:0] dt);
        @(negedge SYS_CLK);
        REG_ADDR  = ad;
        REG_WDATA = dt;
        REG_WR    = 1'b1;
        @(negedge SYS_CLK);
        REG_WR = 1'b0;
        if (ad == 16'h2C02) m_cfg = dt & 8'hCA;
    endtask

    // Back to back read follows a write with no idle cycle
    task automatic rd(input logic [15:0] ad, input bit b2b = 1'b0);
        if (!b2b) @(negedge SYS_CLK);
        REG_ADDR = ad;
        REG_RD   = 1'b1;
        @(negedge SYS_CLK);
        REG_RD = 1'b0;
        chk("rvalid", {7'h00, REG_RVALID}, 8'h01);
        chk("rdata", REG_RDATA, 8'((ad == 16'h2C02) ? (m_cfg | (hs << 2)) : 0));
    endtask

    // Line outputs lag their terms, so settle two edges first
    task automatic lines();
        repeat (2) @(negedge SYS_CLK);
        chk("pullup", {7'h00, DP_PULLUP_EN}, 8'(!((m_cfg >> 6) & 1) && !hs));
        chk("hsterm", {7'h00, HS_TERM_EN}, 8'(!((m_cfg >> 6) & 1) && hs));
        chk("drivek", {7'h00, DRIVE_K}, 8'(((m_cfg >> 1) & 1) && rwu));
        host_u.send(4'h1);
        chk("spvalid", {7'h00, SELF_PWR_VALID}, 8'h01);
        chk("selfpwr", {7'h00, SELF_POWERED}, 8'(!(m_cfg >> 7)));
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        SYS_CLK = 1'b0;
        forever #50 SYS_CLK = ~SYS_CLK;
    end

    initial begin
        repeat (20000) @(posedge SYS_CLK);
        errors++;
        summarize();
    end

    initial begin
        {SRST, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {1'b1, 2'b00, 16'h0000, 8'h00};
        {errors, comparisons, m_cfg, hs, rwu, last_ok} = {32'd0, 32'd0, 32'hC8, 96'd0};
        s = 32'hff817e60;
        seq = '{4'h4, 4'h2, 4'h6, 4'h8, 4'h4};
        repeat (10) @(negedge SYS_CLK);
        SRST = 1'b0;
        rd(16'h2C02);
        lines();
        $display("test reset done");
        for (int i = 0; i < 12; i++) begin
            hs = rnd() & 1;
            host_u.speed(hs[0]);
            a = (i % 4 == 3) ? (rnd() | 1) & 16'hFFFF : 16'h2C02;
            wr(16'(a), 8'(rnd()));
            rd(16'(a), 1'b1);
            rd(16'h2C02);
            lines();
        end
        $display("test registers done");
        // Software raises wake and later drops it itself
        wr(16'h2C02, 8'h02);
        lines();
        foreach (seq[k]) begin
            host_u.send(seq[k]);
            if (seq[k][2]) rwu = 1;
            else rwu = 0;
            lines();
        end
        wr(16'h2C02, 8'h00);
        lines();
        $display("test wakeup done");
        for (int j = 0; j < 2; j++) begin
            wr(16'h2C02, j ? 8'h08 : 8'h00);
            for (int i = 0; i < 12; i++) begin
                if (i == 6) begin
                    host_u.send(4'h8);
                    last_ok = 0;
                end
                d = rnd() & 1;
                e = rnd() & 1;
                host_u.buf_tx(uec_pkg::uec_dir_t'(d[0]), 4'(e));
                chk("joinvalid", {7'h00, BUF_JOIN_VALID}, 8'h01);
                chk("join", {7'h00, BUF_JOIN}, 8'(j && last_ok && d == last_dir && e == last_ep));
                {last_ok, last_dir, last_ep} = {32'd1, d, e};
            end
        end
        $display("test join done");
        summarize();
    end
endmodule
